// ---- ais_pkg.sv ----
// Package for the conversion input selection block
// Assumes a 16-bit core register port and a 40 MHz core clock
package ais_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] AIS_ADDR_CONV_CTRL = 8'h30;
    localparam logic [7:0] AIS_ADDR_SRC_SEL = 8'h3a;
    localparam logic [15:0] AIS_CONV_CTRL_RST = 16'h0000;
    localparam logic [15:0] AIS_SRC_SEL_RST = 16'h0000;
    localparam logic [15:0] AIS_CONV_CTRL_MASK = 16'h03ff;
    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int AIS_CHAN_EN_LSB = 0;
    localparam int AIS_SLOT_EN_LSB = 4;
    localparam int AIS_SEQ_LSB = 8;
    localparam int AIS_SRC_W = 4;
    localparam int AIS_NUM_POS = 8;
    localparam int AIS_RES_W = 24;
    // ------------------------------------------------------------
    // Sequence commands
    // ------------------------------------------------------------
    localparam logic [1:0] AIS_SEQ_STOP_IDLE = 2'h0;
    localparam logic [1:0] AIS_SEQ_SINGLE = 2'h1;
    localparam logic [1:0] AIS_SEQ_CONT = 2'h2;
    localparam logic [1:0] AIS_SEQ_STOP_PDN = 2'h3;
    // ------------------------------------------------------------
    // Source codes
    // ------------------------------------------------------------
    localparam logic [3:0] AIS_SRC_ANALOGUE_GROUND = 4'h0;
    localparam logic [3:0] AIS_SRC_LAST_SHARED = 4'h9;
    localparam logic [3:0] AIS_SRC_FIRST_LOCAL = 4'ha;
    localparam logic [3:0] AIS_SRC_LAST_LOCAL = 4'hd;
    typedef enum logic [1:0] {AIS_IDLE, AIS_PICK, AIS_CONV} ais_state_t;
endpackage

// ---- ais_result_mem.sv ----
// Result store for the channel and diagnostic conversions
// Assumes one write port and one read port on the same clock
`timescale 1ns/100ps
module ais_result_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 24,
    parameter int AW = 3
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // Write port
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [WIDTH-1:0] i_wr_data,
    // Read port
    input wire logic [AW-1:0] i_rd_addr,
    output logic [WIDTH-1:0] o_rd_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] rd_q;

    // Contents are not reset; read data register is
    always_ff @(posedge i_mclk)
    begin
        if (i_wr_en)
        begin
            mem_q[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rd_q <= '0;
        end
        else
        begin
            rd_q <= mem_q[i_rd_addr];
        end
    end

    assign o_rd_data = rd_q;
endmodule

// ---- ais_input_select.sv ----
// Conversion input selection and sequencer for the shared converter
// Assumes a core register port and a converter that pulses done per conversion
`timescale 1ns/100ps
// Function
// - Control bits 0..3 enable channels A..D, results to entries 0..3.
// - Control bits 4..6 enable diagnostic slots 0..2, results to matching entries.
// - Control bit 7 enables diagnostic slot 3, result to entry 7.
// - Continuous mode repeatedly steps through only enabled channels and slots.
// - Source register holds four 4-bit fields, slot 3 at top, slot 0 lowest.
// - Codes 0000..1001 route the slot to shared supply or sensor nodes.
// - Codes 1010..1101 route slot n to points of channel n.
// - Codes 1110 and 1111 route the slot to analogue ground.
// - Source register at offset 0x3a, reset 0x0000, all slots on ground.
module ais_input_select
    import ais_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // Register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    // Converter side
    output logic o_conv_start,
    output logic o_conv_is_slot,
    output logic [1:0] o_conv_index,
    output logic [3:0] o_route_code,
    output logic o_route_local,
    output logic o_busy,
    input wire logic i_conv_done,
    input wire logic [ais_pkg::AIS_RES_W-1:0] i_conv_result,
    // Result readback
    input wire logic [2:0] i_res_addr,
    output logic [ais_pkg::AIS_RES_W-1:0] o_res_data
);
    import ais_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Undefined codes fall back to ground
    function automatic logic [3:0] src_decode(input logic [3:0] code);
        if (code > AIS_SRC_LAST_LOCAL)
            return AIS_SRC_ANALOGUE_GROUND;
        return code;
    endfunction

    function automatic logic src_is_local(input logic [3:0] code);
        return (code >= AIS_SRC_FIRST_LOCAL) && (code <= AIS_SRC_LAST_LOCAL);
    endfunction

    // ------------------------------------------------------------
    // Registers and sequencer state
    // ------------------------------------------------------------
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] src_q, src_d;
    logic [7:0] en_snap_q, en_snap_d;
    logic [15:0] src_snap_q, src_snap_d;
    logic [3:0] cur_q, cur_d;
    logic cont_q, cont_d;
    logic start_q, start_d;
    logic [3:0] route_q, route_d;
    logic local_q, local_d;
    logic [15:0] rdata_q, rdata_d;
    ais_state_t state_q, state_d;
    logic [1:0] seq_cmd;
    logic wr_seq;
    logic found;
    logic [3:0] next_pos;
    logic mem_wr;
    logic [3:0] field;

    assign seq_cmd = ctrl_q[AIS_SEQ_LSB+:2];
    assign wr_seq = i_reg_wr && (i_reg_addr == AIS_ADDR_CONV_CTRL);

    // Search for the next enabled position at or after the cursor
    always_comb
    begin
        found = 1'b0;
        next_pos = 4'h0;
        for (int i = AIS_NUM_POS - 1; i >= 0; i--)
        begin
            if ((4'(i) >= cur_q) && en_snap_q[i])
            begin
                found = 1'b1;
                next_pos = 4'(i);
            end
        end
    end

    assign field = src_snap_q[next_pos[1:0]*AIS_SRC_W+:AIS_SRC_W];

    always_comb
    begin
        ctrl_d = ctrl_q;
        src_d = src_q;
        en_snap_d = en_snap_q;
        src_snap_d = src_snap_q;
        cur_d = cur_q;
        cont_d = cont_q;
        start_d = 1'b0;
        route_d = route_q;
        local_d = local_q;
        state_d = state_q;
        mem_wr = 1'b0;
        rdata_d = rdata_q;
        if (wr_seq)
        begin
            ctrl_d = i_reg_wdata & AIS_CONV_CTRL_MASK;
        end
        if (i_reg_wr && (i_reg_addr == AIS_ADDR_SRC_SEL))
        begin
            src_d = i_reg_wdata;
        end
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                AIS_ADDR_CONV_CTRL: rdata_d = ctrl_q;
                AIS_ADDR_SRC_SEL: rdata_d = src_q;
                default: rdata_d = 16'h0000;
            endcase
        end
        case (state_q)
            AIS_IDLE:
            begin
                if (wr_seq && ((i_reg_wdata[AIS_SEQ_LSB+:2] == AIS_SEQ_SINGLE) ||
                    (i_reg_wdata[AIS_SEQ_LSB+:2] == AIS_SEQ_CONT)))
                begin
                    // Snapshot at sequence start so mid-pass writes wait
                    en_snap_d = i_reg_wdata[7:0];
                    src_snap_d = src_q;
                    cont_d = (i_reg_wdata[AIS_SEQ_LSB+:2] == AIS_SEQ_CONT);
                    cur_d = 4'h0;
                    state_d = AIS_PICK;
                end
            end
            AIS_PICK:
            begin
                if (found)
                begin
                    cur_d = next_pos;
                    start_d = 1'b1;
                    if (next_pos[2])
                    begin
                        route_d = src_decode(field);
                        local_d = src_is_local(field);
                    end
                    else
                    begin
                        route_d = AIS_SRC_ANALOGUE_GROUND;
                        local_d = 1'b0;
                    end
                    state_d = AIS_CONV;
                end
                else if (cont_q && (seq_cmd == AIS_SEQ_CONT))
                begin
                    en_snap_d = ctrl_q[7:0];
                    src_snap_d = src_q;
                    cur_d = 4'h0;
                end
                else
                begin
                    cont_d = 1'b0;
                    state_d = AIS_IDLE;
                end
            end
            AIS_CONV:
            begin
                if (i_conv_done)
                begin
                    mem_wr = 1'b1;
                    cur_d = cur_q + 4'h1;
                    state_d = AIS_PICK;
                end
            end
            default: state_d = AIS_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ctrl_q <= AIS_CONV_CTRL_RST;
            src_q <= AIS_SRC_SEL_RST;
            en_snap_q <= 8'h00;
            src_snap_q <= AIS_SRC_SEL_RST;
            cur_q <= 4'h0;
            cont_q <= 1'b0;
            start_q <= 1'b0;
            route_q <= AIS_SRC_ANALOGUE_GROUND;
            local_q <= 1'b0;
            rdata_q <= 16'h0000;
            state_q <= AIS_IDLE;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            src_q <= src_d;
            en_snap_q <= en_snap_d;
            src_snap_q <= src_snap_d;
            cur_q <= cur_d;
            cont_q <= cont_d;
            start_q <= start_d;
            route_q <= route_d;
            local_q <= local_d;
            rdata_q <= rdata_d;
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Result store
    // ------------------------------------------------------------
    // Positions 0..3 are channels, 4..7 diagnostic slots
    ais_result_mem #(
        .DEPTH(AIS_NUM_POS),
        .WIDTH(AIS_RES_W),
        .AW(3)
    ) u_mem (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_wr_en(mem_wr),
        .i_wr_addr(cur_q[2:0]),
        .i_wr_data(i_conv_result),
        .i_rd_addr(i_res_addr),
        .o_rd_data(o_res_data)
    );

    assign o_reg_rdata = rdata_q;
    assign o_conv_start = start_q;
    assign o_conv_is_slot = cur_q[2];
    assign o_conv_index = cur_q[1:0];
    assign o_route_code = route_q;
    assign o_route_local = local_q;
    assign o_busy = (state_q != AIS_IDLE);
endmodule

// ---- ais_input_select_monitor.sv ----
// Port checks for the conversion input selection block
// Assumes one core clock and an active low asynchronous reset
`timescale 1ns/100ps
module ais_monitor
    import ais_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic [15:0] o_reg_rdata,
    input wire logic o_conv_start,
    input wire logic o_conv_is_slot,
    input wire logic [1:0] o_conv_index,
    input wire logic [3:0] o_route_code,
    input wire logic o_route_local,
    input wire logic o_busy,
    input wire logic i_conv_done
);
    // ----
    // Checks
    // ----
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    sequence s_start_cmd;
        i_reg_wr && i_reg_addr == AIS_ADDR_CONV_CTRL
            && i_reg_wdata[AIS_SEQ_LSB+:2] == AIS_SEQ_SINGLE
            && (|i_reg_wdata[7:0]) && !o_busy;
    endsequence
    sequence s_pick_start;
        o_busy ##1 o_conv_start;
    endsequence
    chk_start_latency: assert property (s_start_cmd |=> s_pick_start)
        else $error("start pulse late");
    chk_start_pulse: assert property (o_conv_start |=> !o_conv_start)
        else $error("start pulse too long");
    chk_start_busy: assert property (o_conv_start |-> o_busy)
        else $error("start while idle");
    chk_chan_route: assert property (o_conv_start && !o_conv_is_slot |->
        o_route_code == AIS_SRC_ANALOGUE_GROUND && !o_route_local)
        else $error("channel route not ground");
    chk_code_range: assert property (o_conv_start |-> o_route_code <= AIS_SRC_LAST_LOCAL)
        else $error("undefined route code");
    chk_local_flag: assert property (o_conv_start |->
        o_route_local == (o_route_code >= AIS_SRC_FIRST_LOCAL))
        else $error("local flag wrong");
    chk_ctrl_upper: assert property (i_reg_rd && i_reg_addr == AIS_ADDR_CONV_CTRL |=>
        o_reg_rdata[15:10] == 6'h00)
        else $error("control upper bits set");
    chk_unmapped_read: assert property (i_reg_rd && i_reg_addr != AIS_ADDR_CONV_CTRL
        && i_reg_addr != AIS_ADDR_SRC_SEL |=> o_reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_reset_idle: assert property ($rose(i_arst_n) |-> !o_busy && o_route_code == 4'h0)
        else $error("not idle after reset");
    // A done in the start cycle legally moves the cursor on; the route must still hold
    chk_hold_route: assert property (o_conv_start |=>
        $stable(o_route_code) && ($past(i_conv_done) || $stable(o_conv_index)))
        else $error("selection moved in conversion");
endmodule
bind ais_input_select ais_monitor mon_u (.i_mclk, .i_arst_n, .i_reg_wr, .i_reg_rd,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_conv_start, .o_conv_is_slot,
    .o_conv_index, .o_route_code, .o_route_local, .o_busy, .i_conv_done);

// ---- test_adc_input_select.sv ----
// Self-checking bench for the conversion input selection block
// Assumes the bench plays both register host and converter
`timescale 1ns/100ps
module test_adc_input_select;
    import ais_pkg::*;
    logic i_mclk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic [15:0] o_reg_rdata;
    logic o_conv_start, o_conv_is_slot, o_route_local, o_busy;
    logic [1:0] o_conv_index;
    logic [3:0] o_route_code;
    logic i_conv_done = 1'b0;
    logic [AIS_RES_W-1:0] i_conv_result = 24'h000000;
    logic [2:0] i_res_addr = 3'h0;
    // Result tag per pass, so a stale entry from an earlier pass cannot pass a readback
    logic [7:0] res_tag = 8'ha0;
    logic [AIS_RES_W-1:0] o_res_data;
    int n_errors = 0;
    int comparisons = 0;
    always #12.5 i_mclk = ~i_mclk;
    ais_input_select dut_u (.i_mclk, .i_arst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr,
        .i_reg_wdata, .o_reg_rdata, .o_conv_start, .o_conv_is_slot, .o_conv_index,
        .o_route_code, .o_route_local, .o_busy, .i_conv_done, .i_conv_result,
        .i_res_addr, .o_res_data);
    // ----
    // Drivers
    // ----
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge i_mclk);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_mclk);
        i_reg_wr = 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
        @(negedge i_mclk);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(negedge i_mclk);
        i_reg_rd = 1'b0;
        check({8'h00, o_reg_rdata}, {8'h00, exp});
    endtask
    // Optional control write lands mid-conversion, so it must not disturb this pass
    task automatic conv_pos(input int p, input logic [3:0] r, input logic l,
        input logic w, input logic [15:0] d);
        int k;
        k = 0;
        while (o_conv_start !== 1'b1 && k < 20)
        begin
            @(negedge i_mclk);
            k++;
        end
        check(o_conv_start, 1'b1);
        check(o_conv_is_slot, p[2]);
        check(o_conv_index, p[1:0]);
        check(o_route_code, r);
        check(o_route_local, l);
        if (w)
            reg_wr(AIS_ADDR_CONV_CTRL, d);
        i_conv_done = 1'b1;
        i_conv_result = {res_tag, 16'(p)};
        @(negedge i_mclk);
        i_conv_done = 1'b0;
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (o_busy !== 1'b0 && k < 20)
        begin
            @(negedge i_mclk);
            k++;
        end
        check(o_busy, 1'b0);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_regs();
        reg_rd(AIS_ADDR_SRC_SEL, 16'h0000);
        reg_rd(AIS_ADDR_CONV_CTRL, 16'h0000);
        reg_wr(AIS_ADDR_SRC_SEL, 16'hdcba);
        reg_rd(AIS_ADDR_SRC_SEL, 16'hdcba);
        reg_wr(AIS_ADDR_CONV_CTRL, 16'hfcff);
        reg_rd(AIS_ADDR_CONV_CTRL, 16'h00ff);
        reg_wr(8'h3b, 16'hffff);
        reg_rd(8'h3b, 16'h0000);
        reg_rd(AIS_ADDR_SRC_SEL, 16'hdcba);
    endtask
    task automatic t_route();
        logic [3:0] c;
        int s;
        for (int i = 0; i < 16; i++)
        begin
            c = 4'(i);
            s = i % 4;
            reg_wr(AIS_ADDR_SRC_SEL, 16'(c) << (4 * s));
            reg_wr(AIS_ADDR_CONV_CTRL, 16'h0100 | (16'h0010 << s));
            conv_pos(4 + s, (c > 4'hd) ? 4'h0 : c, c inside {[4'ha:4'hd]}, 1'b0, 16'h0000);
            wait_idle();
        end
    endtask
    task automatic t_seq(input logic [7:0] e);
        res_tag = e;
        reg_wr(AIS_ADDR_SRC_SEL, 16'h0000);
        reg_wr(AIS_ADDR_CONV_CTRL, {6'h00, AIS_SEQ_SINGLE, e});
        for (int p = 0; p < 8; p++)
            if (e[p])
                conv_pos(p, 4'h0, 1'b0, 1'b0, 16'h0000);
        wait_idle();
        for (int p = 0; p < 8; p++)
            if (e[p])
            begin
                i_res_addr = 3'(p);
                @(negedge i_mclk);
                check(o_res_data, {e, 16'(p)});
            end
    endtask
    task automatic t_cont();
        reg_wr(AIS_ADDR_CONV_CTRL, {6'h00, AIS_SEQ_CONT, 8'h81});
        conv_pos(0, 4'h0, 1'b0, 1'b1, {6'h00, AIS_SEQ_CONT, 8'h02});
        conv_pos(7, 4'h0, 1'b0, 1'b0, 16'h0000);
        conv_pos(1, 4'h0, 1'b0, 1'b1, {6'h00, AIS_SEQ_STOP_IDLE, 8'h02});
        wait_idle();
    endtask
    // ----
    // Main
    // ----
    task automatic results();
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(negedge i_mclk);
        i_arst_n = 1'b1;
        t_regs();
        t_route();
        t_seq(8'hff);
        t_seq(8'ha5);
        t_cont();
        results();
    end
    // Whole run is well under 1500 cycles
    initial
    begin
        #(4000 * 25);
        n_errors++;
        results();
    end
endmodule
